// ---- inc/cms_pkg.sv ----
// package for the maintenance status and interrupt block of the central control unit
// assumes one clock domain shared with the scan-string access logic
package cms_pkg;

    // -----------------------------------------------------------------
    // scan-string register selects
    // -----------------------------------------------------------------
    localparam logic [1:0] CMS_SEL_STAT_A = 2'h0;
    localparam logic [1:0] CMS_SEL_STAT_B = 2'h1;
    localparam logic [1:0] CMS_SEL_STAT_C = 2'h2;
    localparam logic [1:0] CMS_SEL_CARD = 2'h3;

    // -----------------------------------------------------------------
    // field positions and reset values
    // -----------------------------------------------------------------
    localparam int CMS_W = 8;
    localparam int CMS_A_MAINT_OP_ERR = 0;
    localparam int CMS_A_ADDR_EXC = 1;
    localparam int CMS_A_OUT_PORT70 = 2;
    localparam int CMS_A_ADAPTER_LOAD = 3;
    localparam int CMS_A_PROGRAM_LOAD = 4;
    localparam int CMS_CARD_PROC_ERR = 0;
    localparam int CMS_CARD_DOR_PAR = 1;
    localparam int CMS_S1_DISABLE = 1;
    localparam int CMS_S1_HIGH_IRQ = 5;
    localparam int CMS_S1_LOW_IRQ = 7;
    localparam logic [7:0] CMS_A_HIGH_MASK = 8'h1F;
    localparam logic [7:0] CMS_LATCH_RESET = 8'h00;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] sel;
        logic [7:0] data;
    } cms_scan_req_t;

    typedef struct packed {
        logic interface_err;
        logic storage_ctl_err;
        logic bus_in_err;
        logic storage_protect;
        logic addr_exception;
        logic timeout;
    } cms_string_err_t;

endpackage

// ---- logic/cms_latch_reg.sv ----
// one status register of individually settable latches
// assumes set pulses and scan loads come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module cms_latch_reg
    import cms_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [CMS_W-1:0] load_data_in,
    input wire logic [CMS_W-1:0] set_in,
    output logic [CMS_W-1:0] q_out
);
    logic [CMS_W-1:0] q_q;
    logic [CMS_W-1:0] q_d;

    // -----------------------------------------------------------------
    // scan load, hardware set wins over a clear in the same cycle
    // -----------------------------------------------------------------
    always_comb
    begin
        q_d = load_in ? load_data_in : q_q;
        q_d = q_d | set_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            q_q <= CMS_LATCH_RESET;
        else
            q_q <= q_d;
    end

    assign q_out = q_q;
endmodule
`default_nettype wire

// ---- logic/cms_status_irq.sv ----
// status latches A, B, C and card errors with high and low level requests
// assumes init reset, scan access and error sources all on CLK_IN
// set pulses, string errors and parity faults are same-clock levels
// requests and the status 1 view lag a latch change by one clock
// card register bits above the two card latches are spare scan bits
`timescale 1ns/10ps
`default_nettype none
module cms_status_irq
    import cms_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire cms_scan_req_t SCAN_REQ_IN,
    input wire logic [CMS_W-1:0] STAT_A_SET_IN,
    input wire logic [CMS_W-1:0] STAT_B_SET_IN,
    input wire logic [CMS_W-1:0] STAT_C_SET_IN,
    input wire cms_string_err_t STRING_ERR_IN,
    input wire logic PROC_PARITY_ERR_IN,
    input wire logic DOR_PARITY_ERR_IN,
    input wire logic IRQ_DISABLE_IN,
    output logic [CMS_W-1:0] SCAN_RDATA_OUT,
    output logic SCAN_RVALID_OUT,
    output logic HIGH_LEVEL_IRQ_REQUEST_OUT,
    output logic LOW_LEVEL_IRQ_REQUEST_OUT,
    output logic [CMS_W-1:0] MAINT_STATUS1_OUT,
    output logic PARITY_GATE_OUT
);
    logic [CMS_W-1:0] stat_a;
    logic [CMS_W-1:0] stat_b;
    logic [CMS_W-1:0] stat_c;
    logic [CMS_W-1:0] card;
    logic [CMS_W-1:0] a_set;
    logic [CMS_W-1:0] card_set;
    logic [3:0] load;
    logic gate_q;
    logic high_d;
    logic low_d;
    logic high_q;
    logic low_q;
    logic high_src;
    logic low_src;
    logic [CMS_W-1:0] rdata_q;
    logic rvalid_q;
    logic [CMS_W-1:0] status1_q;

    function automatic logic sel_hit(input logic [1:0] sel, input logic [1:0] which);
        sel_hit = (sel == which);
    endfunction

    // -----------------------------------------------------------------
    // scan-string write decode
    // -----------------------------------------------------------------
    always_comb
    begin
        load = 4'h0;
        if (SCAN_REQ_IN.wr && sel_hit(SCAN_REQ_IN.sel, CMS_SEL_STAT_A))
            load[0] = 1'b1;
        else if (SCAN_REQ_IN.wr && sel_hit(SCAN_REQ_IN.sel, CMS_SEL_STAT_B))
            load[1] = 1'b1;
        else if (SCAN_REQ_IN.wr && sel_hit(SCAN_REQ_IN.sel, CMS_SEL_STAT_C))
            load[2] = 1'b1;
        else if (SCAN_REQ_IN.wr)
            load[3] = 1'b1;
    end

    // -----------------------------------------------------------------
    // set sources
    // -----------------------------------------------------------------
    always_comb
    begin
        a_set = STAT_A_SET_IN;
        // interface error combined with a storage control, bus in, storage protect, address exception or timeout string error
        a_set[CMS_A_MAINT_OP_ERR] = STAT_A_SET_IN[CMS_A_MAINT_OP_ERR]
            | (STRING_ERR_IN.interface_err & (STRING_ERR_IN.storage_ctl_err
            | STRING_ERR_IN.bus_in_err | STRING_ERR_IN.storage_protect
            | STRING_ERR_IN.addr_exception | STRING_ERR_IN.timeout));
        card_set = CMS_LATCH_RESET;
        // parity results reach the card latches only once gated
        card_set[CMS_CARD_PROC_ERR] = gate_q & PROC_PARITY_ERR_IN;
        card_set[CMS_CARD_DOR_PAR] = gate_q & DOR_PARITY_ERR_IN;
    end

    // -----------------------------------------------------------------
    // latch registers
    // -----------------------------------------------------------------
    cms_latch_reg u_stat_a (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .load_in(load[0]),
        .load_data_in(SCAN_REQ_IN.data),
        .set_in(a_set),
        .q_out(stat_a)
    );

    cms_latch_reg u_stat_b (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .load_in(load[1]),
        .load_data_in(SCAN_REQ_IN.data),
        .set_in(STAT_B_SET_IN),
        .q_out(stat_b)
    );

    cms_latch_reg u_stat_c (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .load_in(load[2]),
        .load_data_in(SCAN_REQ_IN.data),
        .set_in(STAT_C_SET_IN),
        .q_out(stat_c)
    );

    cms_latch_reg u_card (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .load_in(load[3]),
        .load_data_in(SCAN_REQ_IN.data),
        .set_in(card_set),
        .q_out(card)
    );

    // -----------------------------------------------------------------
    // parity gate, opened by a read of status A
    // -----------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
            gate_q <= 1'b0;
        else if (SCAN_REQ_IN.rd && sel_hit(SCAN_REQ_IN.sel, CMS_SEL_STAT_A))
            gate_q <= 1'b1;
    end

    // -----------------------------------------------------------------
    // scan-string read answer strobe
    // -----------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
            rvalid_q <= 1'b0;
        else
            rvalid_q <= SCAN_REQ_IN.rd;
    end

    // -----------------------------------------------------------------
    // scan-string read data
    // -----------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
            rdata_q <= CMS_LATCH_RESET;
        else if (!SCAN_REQ_IN.rd)
            rdata_q <= rdata_q;
        else if (sel_hit(SCAN_REQ_IN.sel, CMS_SEL_STAT_A))
            rdata_q <= stat_a;
        else if (sel_hit(SCAN_REQ_IN.sel, CMS_SEL_STAT_B))
            rdata_q <= stat_b;
        else if (sel_hit(SCAN_REQ_IN.sel, CMS_SEL_STAT_C))
            rdata_q <= stat_c;
        else
            rdata_q <= card;
    end

    // -----------------------------------------------------------------
    // interrupt sources
    // -----------------------------------------------------------------
    always_comb
    begin
        high_src = (|(stat_a & CMS_A_HIGH_MASK)) | card[CMS_CARD_PROC_ERR]
            | card[CMS_CARD_DOR_PAR];
        low_src = (|stat_b) | (|stat_c);
    end

    // -----------------------------------------------------------------
    // interrupt requests, gated by the disable control
    // -----------------------------------------------------------------
    always_comb
    begin
        high_d = ~IRQ_DISABLE_IN & high_src;
        low_d = ~IRQ_DISABLE_IN & low_src;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
            high_q <= 1'b0;
        else
            high_q <= high_d;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
            low_q <= 1'b0;
        else
            low_q <= low_d;
    end

    // -----------------------------------------------------------------
    // maintenance status 1 view
    // -----------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
            status1_q <= CMS_LATCH_RESET;
        else
        begin
            status1_q <= CMS_LATCH_RESET;
            status1_q[CMS_S1_DISABLE] <= IRQ_DISABLE_IN;
            status1_q[CMS_S1_HIGH_IRQ] <= high_d;
            status1_q[CMS_S1_LOW_IRQ] <= low_d;
        end
    end

    assign SCAN_RDATA_OUT = rdata_q;
    assign SCAN_RVALID_OUT = rvalid_q;
    assign HIGH_LEVEL_IRQ_REQUEST_OUT = high_q;
    assign LOW_LEVEL_IRQ_REQUEST_OUT = low_q;
    assign MAINT_STATUS1_OUT = status1_q;
    assign PARITY_GATE_OUT = gate_q;
endmodule
`default_nettype wire

// ---- test/cms_status_irq_props.sv ----
// port assertions for the status and interrupt block
// assumes bind onto cms_status_irq, one clock CLK_IN
`timescale 1ns/10ps
`default_nettype none
module cms_status_irq_props
    import cms_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire cms_scan_req_t SCAN_REQ_IN,
    input wire logic [CMS_W-1:0] STAT_A_SET_IN,
    input wire logic [CMS_W-1:0] STAT_B_SET_IN,
    input wire logic [CMS_W-1:0] STAT_C_SET_IN,
    input wire cms_string_err_t STRING_ERR_IN,
    input wire logic IRQ_DISABLE_IN,
    input wire logic SCAN_RVALID_OUT,
    input wire logic HIGH_LEVEL_IRQ_REQUEST_OUT,
    input wire logic LOW_LEVEL_IRQ_REQUEST_OUT,
    input wire logic [CMS_W-1:0] MAINT_STATUS1_OUT,
    input wire logic PARITY_GATE_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    wire logic hi = HIGH_LEVEL_IRQ_REQUEST_OUT;
    wire logic lo = LOW_LEVEL_IRQ_REQUEST_OUT;
    wire logic en = !IRQ_DISABLE_IN;
    sequence s_low_src;
        |{STAT_B_SET_IN, STAT_C_SET_IN} ##1 en;
    endsequence
    sequence s_high_src;
        |(STAT_A_SET_IN & CMS_A_HIGH_MASK) ##1 en;
    endsequence
    sequence s_str_err;
        STRING_ERR_IN.interface_err && |STRING_ERR_IN[4:0] ##1 en;
    endsequence
    sequence s_read_a;
        SCAN_REQ_IN.rd && SCAN_REQ_IN.sel == CMS_SEL_STAT_A;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) RST_IN |=> !hi && !lo)
        else $error("request up after reset");
    a_disable_both: assert property ($past(IRQ_DISABLE_IN) |-> !hi && !lo)
        else $error("request up while disabled");
    a_status_view: assert property (MAINT_STATUS1_OUT[7] == lo && MAINT_STATUS1_OUT[5] == hi)
        else $error("status view differs from requests");
    a_low_set: assert property (s_low_src |=> lo)
        else $error("low request missing");
    a_high_set: assert property (s_high_src |=> hi)
        else $error("high request missing");
    a_string_bit0: assert property (s_str_err |=> hi)
        else $error("string error gave no high request");
    a_low_hold: assert property (lo && !$past(SCAN_REQ_IN.wr) && !SCAN_REQ_IN.wr ##1 en |=> lo)
        else $error("low request dropped");
    a_read_answer: assert property (SCAN_REQ_IN.rd |=> SCAN_RVALID_OUT)
        else $error("read not answered");
    a_gate_open: assert property (s_read_a |=> PARITY_GATE_OUT)
        else $error("gate shut after status A read");
endmodule
bind cms_status_irq cms_status_irq_props props_u (.CLK_IN, .RST_IN, .SCAN_REQ_IN,
    .STAT_A_SET_IN, .STAT_B_SET_IN, .STAT_C_SET_IN, .STRING_ERR_IN, .IRQ_DISABLE_IN,
    .SCAN_RVALID_OUT, .HIGH_LEVEL_IRQ_REQUEST_OUT, .LOW_LEVEL_IRQ_REQUEST_OUT,
    .MAINT_STATUS1_OUT, .PARITY_GATE_OUT);
`default_nettype wire

// ---- test/cms_maint_model.sv ----
// maintenance-side model issuing scan-string reads and writes
// assumes requests are taken on the rising edge of clk_in
`timescale 1ns/10ps
`default_nettype none
module cms_maint_model
    import cms_pkg::*;
(
    input wire logic clk_in,
    output var cms_scan_req_t req_out,
    input wire logic [CMS_W-1:0] rdata_in,
    input wire logic rvalid_in
);
    initial req_out = {1'b0, 1'b0, 2'h0, 8'h00};
    // whole byte per write; data bus shows garbage afterwards
    task automatic scan_write(input logic [1:0] sel, input logic [7:0] data);
        @(negedge clk_in);
        req_out = {1'b1, 1'b0, sel, data};
        @(negedge clk_in);
        req_out.wr = 1'b0;
        req_out.data = ~data;
    endtask
    // reading status A after init opens parity gating; answer within 4 cycles
    task automatic scan_read(input logic [1:0] sel, output logic [7:0] data, output logic ok);
        ok = 1'b0;
        data = 8'h00;
        @(negedge clk_in);
        req_out.rd = 1'b1;
        req_out.sel = sel;
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(negedge clk_in);
            req_out.rd = 1'b0;
            if (rvalid_in === 1'b1)
            begin
                ok = 1'b1;
                data = rdata_in;
            end
        end
    endtask
endmodule
`default_nettype wire

// ---- test/cms_status_irq_bench.sv ----
// self-checking bench for the status and interrupt block
// assumes the maintenance model makes all scan requests
`timescale 1ns/10ps
`default_nettype none
module cms_status_irq_bench
    import cms_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] set_a = 8'h00, set_b = 8'h00, set_c = 8'h00, v, w;
    cms_string_err_t serr = 6'h00;
    logic perr = 1'b0, derr = 1'b0, dis = 1'b0, ok, rvalid, hi, lo, gate;
    logic [7:0] rdata, st1;
    cms_scan_req_t req;
    int fails = 0, check_count = 0, i, s;
    always #25 clk = ~clk;
    cms_status_irq dut_u (.CLK_IN(clk), .RST_IN(rst), .SCAN_REQ_IN(req), .STAT_A_SET_IN(set_a),
        .STAT_B_SET_IN(set_b), .STAT_C_SET_IN(set_c), .STRING_ERR_IN(serr),
        .PROC_PARITY_ERR_IN(perr), .DOR_PARITY_ERR_IN(derr), .IRQ_DISABLE_IN(dis),
        .SCAN_RDATA_OUT(rdata), .SCAN_RVALID_OUT(rvalid), .HIGH_LEVEL_IRQ_REQUEST_OUT(hi),
        .LOW_LEVEL_IRQ_REQUEST_OUT(lo), .MAINT_STATUS1_OUT(st1), .PARITY_GATE_OUT(gate));
    cms_maint_model maint_u (.clk_in(clk), .req_out(req), .rdata_in(rdata), .rvalid_in(rvalid));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic get(input logic [1:0] sel, input logic [7:0] exp, input string what);
        maint_u.scan_read(sel, v, ok);
        if (ok !== 1'b1)
        begin
            fails++;
            $display("BAD %s answer expected 1 seen %b", what, ok);
            stop_test();
        end
        else
            chk(what, exp, v);
    endtask
    task automatic irq(input logic h, input logic l, input string what);
        repeat (3) @(negedge clk);
        chk({what, " view"}, {l, 1'b0, h, 3'h0, dis, 1'b0}, st1);
        chk({what, " lines"}, {6'h00, h, l}, {6'h00, hi, lo});
    endtask
    task automatic pulse(input logic [7:0] a, b, c, input logic [5:0] e, input logic [1:0] p);
        @(negedge clk);
        {set_a, set_b, set_c, serr, perr, derr} = {a, b, c, e, p};
        @(negedge clk);
        {set_a, set_b, set_c, serr, perr, derr} = 32'h0;
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
    endtask
    initial
    begin
        do_reset();
        pulse(8'h00, 8'h00, 8'h00, 6'h00, 2'h3);
        chk("gate", 8'h00, {7'h00, gate});
        get(CMS_SEL_STAT_B, 8'h00, "B init");
        get(CMS_SEL_STAT_C, 8'h00, "C init");
        get(CMS_SEL_STAT_A, 8'h00, "A init");
        chk("gate", 8'h01, {7'h00, gate});
        get(CMS_SEL_CARD, 8'h00, "card init");
        $display("init test done");
        for (s = 0; s < 3; s++)
        begin
            for (i = 0; i < 18; i++)
            begin
                w = (i < 8) ? 8'h01 << i : (i < 16) ? ~(8'h01 << (i - 8)) : (i == 16) ? 8'hFF : 8'h00;
                maint_u.scan_write(s[1:0], w);
                get(s[1:0], w, "latch rw");
            end
        end
        irq(1'b0, 1'b0, "all clear");
        $display("latch test done");
        for (i = 0; i < 16; i++)
        begin
            w = 8'h01 << (i % 8);
            pulse(8'h00, (i < 8) ? w : 8'h00, (i < 8) ? 8'h00 : w, 6'h00, 2'h0);
            irq(1'b0, 1'b1, "low source");
            maint_u.scan_write((i < 8) ? CMS_SEL_STAT_B : CMS_SEL_STAT_C, 8'h00);
            irq(1'b0, 1'b0, "low cleared");
        end
        $display("low test done");
        for (i = 0; i < 8; i++)
        begin
            w = (i < 5) ? 8'h01 << i : (i == 7) ? 8'h20 : 8'h00;
            pulse(w, 8'h00, 8'h00, 6'h00, (i == 5) ? 2'h2 : (i == 6) ? 2'h1 : 2'h0);
            irq(i < 7, 1'b0, "high source");
            maint_u.scan_write((i == 5 || i == 6) ? CMS_SEL_CARD : CMS_SEL_STAT_A, 8'h00);
            irq(1'b0, 1'b0, "high cleared");
        end
        maint_u.scan_write(CMS_SEL_CARD, 8'hFC);
        irq(1'b0, 1'b0, "card spare");
        maint_u.scan_write(CMS_SEL_CARD, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            pulse(8'h00, 8'h00, 8'h00, 6'h20 | (6'h01 << i), 2'h0);
            get(CMS_SEL_STAT_A, {7'h00, i < 5}, "A bit 0");
            irq(i < 5, 1'b0, "string error");
            maint_u.scan_write(CMS_SEL_STAT_A, 8'h00);
        end
        $display("high test done");
        dis = 1'b1;
        pulse(8'h01, 8'h01, 8'h00, 6'h00, 2'h0);
        irq(1'b0, 1'b0, "disabled");
        get(CMS_SEL_STAT_B, 8'h01, "B disabled");
        dis = 1'b0;
        irq(1'b1, 1'b1, "enabled");
        do_reset();
        irq(1'b0, 1'b0, "reinit");
        chk("gate reinit", 8'h00, {7'h00, gate});
        $display("disable test done");
        stop_test();
    end
endmodule
`default_nettype wire
